// File: hdl/acs_top.sv
// conversion sequencer for a 10-bit successive-approximation converter
`timescale 1ns/1ps
module acs_top
	import acs_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog side
	input wire logic comparator_in,
	input wire logic rc_clock_in,
	input wire logic [PIN_W-1:0] port_pins,
	output logic hold_connect,
	output logic [RES_W-1:0] trial_code,
	output logic conversion_done_flag
);

	typedef struct packed {
		acs_state_t state;
		logic converter_on;
		logic go;
		logic [3:0] channel_select;
		logic result_align_select;
		logic [2:0] acquisition_time_select;
		logic [2:0] conversion_clock_select;
		logic [7:0] result_high_byte;
		logic [7:0] result_low_byte;
		logic done;
		logic [PIN_W-1:0] analog_mask;
		logic [4:0] cnt;
		logic [5:0] div;
		logic [RES_W-1:0] sar;
		logic [RES_W-1:0] bitmask;
		logic hold;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic cmp_s1;
		logic rc_s1;
		logic rc_s2;
		logic rc_s3;
		logic [PIN_W-1:0] pin_s1;
		logic [PIN_W-1:0] pin_s2;
	} acs_st_t;

	acs_st_t st_ff;
	acs_st_t nxt_st;

	logic access;
	logic wr;
	logic rc_sel;
	logic tick;
	logic start_go;
	logic abort_go;
	logic [4:0] acq_len;
	logic [RES_W-1:0] res;
	logic [RES_W-1:0] decided;

	assign prdata = st_ff.rdata;
	assign pready = st_ff.rdy;
	assign pslverr = st_ff.err;
	assign hold_connect = st_ff.hold;
	assign trial_code = st_ff.sar;
	assign conversion_done_flag = st_ff.done;

	always_comb begin
		nxt_st = st_ff;
		// one wait state keeps every bus output registered
		access = psel && penable && st_ff.rdy;
		wr = access && pwrite && !st_ff.err;
		rc_sel = (st_ff.conversion_clock_select & CKS_RC_MASK) == CKS_RC_MASK;
		tick = rc_sel ? (st_ff.rc_s2 && !st_ff.rc_s3) :
			(st_ff.div == acs_div_last(st_ff.conversion_clock_select));
		acq_len = ACQ_TAD[st_ff.acquisition_time_select];
		res = '0;
		decided = '0;
		start_go = 1'b0;
		abort_go = 1'b0;

		// synchronisers for pins from outside the clock domain
		// comparator answers our own registered trial code, so one flop
		// is enough; a second would miss the two-clock bit period
		nxt_st.cmp_s1 = comparator_in;
		nxt_st.rc_s1 = rc_clock_in;
		nxt_st.rc_s2 = st_ff.rc_s1;
		nxt_st.rc_s3 = st_ff.rc_s2;
		nxt_st.pin_s1 = port_pins;
		nxt_st.pin_s2 = st_ff.pin_s1;

		// bus answer: register read data in the same cycle as pready
		nxt_st.rdy = psel && penable && !st_ff.rdy;
		nxt_st.err = 1'b0;
		nxt_st.rdata = '0;
		if (psel && penable && !st_ff.rdy) begin
			unique case (paddr)
				OFS_CTRL: begin
					nxt_st.rdata[CTRL_ON] = st_ff.converter_on;
					nxt_st.rdata[CTRL_GO] = st_ff.go;
					nxt_st.rdata[CTRL_CH_LO+:4] = st_ff.channel_select;
				end
				OFS_TIMING: begin
					nxt_st.rdata[TIM_ALIGN] = st_ff.result_align_select;
					nxt_st.rdata[TIM_ACQ_LO+:3] = st_ff.acquisition_time_select;
					nxt_st.rdata[2:0] = st_ff.conversion_clock_select;
				end
				OFS_RES_HI: nxt_st.rdata[7:0] = st_ff.result_high_byte;
				OFS_RES_LO: nxt_st.rdata[7:0] = st_ff.result_low_byte;
				OFS_STATUS: begin
					nxt_st.rdata[STAT_DONE] = st_ff.done;
					nxt_st.rdata[STAT_HOLD] = st_ff.hold;
				end
				OFS_AMASK: nxt_st.rdata[PIN_W-1:0] = st_ff.analog_mask;
				OFS_PORT: nxt_st.rdata[PIN_W-1:0] =
					st_ff.pin_s2 & ~st_ff.analog_mask;
				default: nxt_st.err = 1'b1;
			endcase
		end

		// register writes
		if (wr && pstrb[0]) begin
			unique case (paddr)
				OFS_CTRL: begin
					nxt_st.converter_on = pwdata[CTRL_ON];
					nxt_st.channel_select = pwdata[CTRL_CH_LO+:4];
					// go with the power-on write is ignored
					start_go = pwdata[CTRL_GO] && pwdata[CTRL_ON] &&
						st_ff.converter_on && st_ff.state == ACS_IDLE;
					abort_go = !pwdata[CTRL_GO] && st_ff.go;
				end
				OFS_TIMING: begin
					nxt_st.result_align_select = pwdata[TIM_ALIGN];
					nxt_st.acquisition_time_select = pwdata[TIM_ACQ_LO+:3];
					nxt_st.conversion_clock_select = pwdata[2:0];
				end
				OFS_RES_HI: nxt_st.result_high_byte = pwdata[7:0];
				OFS_RES_LO: nxt_st.result_low_byte = pwdata[7:0];
				OFS_STATUS: begin
					if (pwdata[STAT_DONE]) begin
						nxt_st.done = 1'b0;
					end
				end
				OFS_AMASK: nxt_st.analog_mask[7:0] = pwdata[7:0];
				default: ;
			endcase
		end
		if (wr && pstrb[1] && paddr == OFS_AMASK) begin
			nxt_st.analog_mask[15:8] = pwdata[15:8];
		end

		// bit period divider runs only in timed states
		if (st_ff.state == ACS_IDLE || st_ff.state == ACS_DLY || tick) begin
			nxt_st.div = '0;
		end else begin
			nxt_st.div = st_ff.div + 6'h01;
		end

		// channel and direction never gate the sequence
		unique case (st_ff.state)
			ACS_IDLE: begin
				nxt_st.hold = 1'b1;
				if (start_go) begin
					nxt_st.go = 1'b1;
					if (st_ff.acquisition_time_select == 3'h0 || rc_sel) begin
						nxt_st.state = ACS_DLY;
						nxt_st.cnt = TCY_CLKS - 5'h01;
					end else begin
						nxt_st.state = ACS_ACQ;
						nxt_st.cnt = acq_len - 5'h01;
					end
				end
			end
			ACS_DLY: begin
				if (st_ff.cnt == '0) begin
					if (st_ff.acquisition_time_select == 3'h0) begin
						nxt_st.state = ACS_CONV;
						nxt_st.hold = 1'b0;
						nxt_st.cnt = '0;
						nxt_st.sar = '0;
					end else begin
						nxt_st.state = ACS_ACQ;
						nxt_st.cnt = acq_len - 5'h01;
					end
				end else begin
					nxt_st.cnt = st_ff.cnt - 5'h01;
				end
			end
			ACS_ACQ: begin
				if (tick) begin
					if (st_ff.cnt == '0) begin
						nxt_st.state = ACS_CONV;
						nxt_st.hold = 1'b0;
						nxt_st.sar = '0;
					end else begin
						nxt_st.cnt = st_ff.cnt - 5'h01;
					end
				end
			end
			ACS_CONV: begin
				if (tick) begin
					nxt_st.cnt = st_ff.cnt + 5'h01;
					if (st_ff.cnt == '0) begin
						nxt_st.bitmask = {1'b1, {(RES_W-1){1'b0}}};
						nxt_st.sar = {1'b1, {(RES_W-1){1'b0}}};
					end else begin
						// one decision per bit period, msb first
						decided = st_ff.cmp_s1 ? st_ff.sar :
							(st_ff.sar & ~st_ff.bitmask);
						nxt_st.bitmask = st_ff.bitmask >> 1;
						nxt_st.sar = decided | (st_ff.bitmask >> 1);
					end
					if (st_ff.cnt == CONV_TAD - 5'h01) begin
						res = decided;
						if (st_ff.result_align_select) begin
							nxt_st.result_high_byte = {6'h00, res[9:8]};
							nxt_st.result_low_byte = res[7:0];
						end else begin
							nxt_st.result_high_byte = res[9:2];
							nxt_st.result_low_byte = {res[1:0], 6'h00};
						end
						nxt_st.go = 1'b0;
						nxt_st.done = 1'b1;
						nxt_st.state = ACS_WAIT;
						nxt_st.cnt = '0;
					end
				end
			end
			ACS_WAIT: begin
				nxt_st.hold = 1'b0;
				if (tick) begin
					if (st_ff.cnt == WAIT_TAD - 5'h01) begin
						nxt_st.state = ACS_IDLE;
						nxt_st.hold = 1'b1;
					end else begin
						nxt_st.cnt = st_ff.cnt + 5'h01;
					end
				end
			end
		endcase

		// go only drops on completion, abort or power-off
		if (abort_go && st_ff.state != ACS_IDLE && st_ff.state != ACS_WAIT &&
			!(nxt_st.state == ACS_WAIT && st_ff.state == ACS_CONV)) begin
			nxt_st.go = 1'b0;
			nxt_st.state = ACS_WAIT;
			nxt_st.hold = 1'b0;
			nxt_st.cnt = '0;
		end
		// switched off: sequence stops at once
		if (!nxt_st.converter_on) begin
			nxt_st.go = 1'b0;
			nxt_st.state = ACS_IDLE;
			nxt_st.hold = 1'b1;
		end
	end

	// reset clears control and result alike, every field to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : acs_top

// File: hdl/acs_pkg.sv
// shared constants and types for the conversion sequencer
package acs_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIMING = 8'h04;
	localparam logic [7:0] OFS_RES_HI = 8'h08;
	localparam logic [7:0] OFS_RES_LO = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_AMASK = 8'h14;
	localparam logic [7:0] OFS_PORT = 8'h18;
	// field positions
	localparam int CTRL_ON = 0;
	localparam int CTRL_GO = 1;
	localparam int CTRL_CH_LO = 2;
	localparam int TIM_ALIGN = 7;
	localparam int TIM_ACQ_LO = 3;
	localparam int STAT_DONE = 0;
	localparam int STAT_HOLD = 1;
	// timing: clock rate and instruction cycle
	localparam int PCLK_HZ = 40_000_000;
	localparam int TCY_OSC = 4;
	localparam logic [4:0] TCY_CLKS = 5'(TCY_OSC);
	localparam logic [4:0] CONV_TAD = 5'h0B;
	localparam logic [4:0] WAIT_TAD = 5'h02;
	localparam int RES_W = 10;
	localparam int PIN_W = 16;
	localparam logic [2:0] CKS_RC_MASK = 3'h3;
	// acquisition field to bit periods
	localparam logic [4:0] ACQ_TAD [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
		5'h08, 5'h0C, 5'h10, 5'h14};

	typedef enum logic [2:0] {
		ACS_IDLE,
		ACS_DLY,
		ACS_ACQ,
		ACS_CONV,
		ACS_WAIT
	} acs_state_t;

	// oscillator periods per bit period, minus one
	function automatic logic [5:0] acs_div_last(input logic [2:0] cks);
		logic [5:0] r;
		r = 6'h01;
		case (cks)
			3'h0: r = 6'h01;
			3'h4: r = 6'h03;
			3'h1: r = 6'h07;
			3'h5: r = 6'h0F;
			3'h2: r = 6'h1F;
			3'h6: r = 6'h3F;
			default: r = 6'h01;
		endcase
		return r;
	endfunction : acs_div_last
endpackage : acs_pkg

// File: testbench/acs_monitor.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
module acs_monitor
	import acs_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// converter
	input wire logic hold_connect,
	input wire logic conversion_done_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_ready_answer: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero");
	a_conv_length: assert property ($fell(hold_connect) |=>
		(!$rose(conversion_done_flag)) [*8])
		else $error("conversion too short");
	// divide-by-two is the fastest: two periods are four clocks
	a_wait_low: assert property ($rose(conversion_done_flag) |->
		!hold_connect [*4])
		else $error("resampled too early");
	a_resample_soon: assert property ($rose(conversion_done_flag) |->
		##[4:1000] hold_connect)
		else $error("sampling not resumed");
	a_done_sticky: assert property (conversion_done_flag &&
		!(psel && pwrite && paddr == OFS_STATUS) |=> conversion_done_flag)
		else $error("done flag lost");
	a_done_held: assert property ($rose(conversion_done_flag) |->
		!$past(hold_connect))
		else $error("done while sampling");
endmodule : acs_monitor

bind acs_top acs_monitor mon (.*);

// File: testbench/acs_analog_model.sv
// comparator and rc oscillator of the analog side
`timescale 1ns/1ps
module acs_analog_model (
	// converter side
	input wire logic [9:0] trial_code,
	input wire logic [9:0] vin,
	output logic comparator_in,
	output logic rc_clock_in
);
	// free-running oscillator, unrelated to pclk
	initial rc_clock_in = 1'b0;
	always #140 rc_clock_in = ~rc_clock_in;
	// half-step offset so the result equals vin whatever the tie rule
	assign comparator_in = {vin, 1'b1} > {trial_code, 1'b0};
endmodule : acs_analog_model

// File: testbench/test_acs_top.sv
// register-level tests of the conversion sequencer
`timescale 1ns/1ps
module test_acs_top
	import acs_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, comparator_in, rc_clock_in, err, hold_q = 0;
	logic hold_connect, conversion_done_flag;
	logic [15:0] port_pins = 16'hFFFF;
	logic [9:0] trial_code, vin = 10'h000;
	int n_fail = 0, n_compared = 0, cyc = 0, t_go, t_fall, t_rise;
	localparam int AQ [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

	always #12.5 pclk = ~pclk;
	acs_top dut (.*);
	acs_analog_model ana (.*);

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		hold_q <= hold_connect;
		if (hold_q && !hold_connect) t_fall <= cyc;
		if (!hold_q && hold_connect) t_rise <= cyc;
	end

	task chk(input string s, input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, ex, seen);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		t_go = cyc;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb

	task rd(input logic [7:0] a, input string s, input logic [31:0] ex);
		apb(0, a, 32'h0);
		chk(s, q, ex);
	endtask : rd

	task wait_hold(input logic v);
		while (hold_connect !== v) @(posedge pclk);
	endtask : wait_hold

	task conv(input logic [2:0] cks, acq, input logic al, input logic [9:0] v);
		int dv, ex, g;
		logic in_win;
		logic [31:0] ex_hi, ex_lo;
		dv = 2 << (2 * cks[1:0] + cks[2]);
		ex = (acq == 0) ? 4 : AQ[acq] * dv;
		ex_hi = al ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
		ex_lo = {24'h0, al ? v[7:0] : {v[1:0], 6'h0}};
		vin <= v;
		apb(1, OFS_TIMING, {24'h0, al, 1'b0, acq, cks});
		apb(1, OFS_STATUS, 32'h1);
		apb(1, OFS_CTRL, 32'h3);
		g = t_go;
		rd(OFS_CTRL, "go busy", 32'h3);
		wait_hold(0);
		wait_hold(1);
		@(posedge pclk);
		// rc timing is not pclk-locked, so only divider codes are timed
		if (cks[1:0] != 2'h3) begin
			in_win = t_fall >= g + ex && t_fall < g + ex + dv + 4;
			chk("start", {31'h0, in_win}, 32'h1);
			chk("hold low", 32'(t_rise - t_fall), 32'(13 * dv));
		end
		chk("trial code", {22'h0, trial_code}, {22'h0, v});
		chk("done pin", {31'h0, conversion_done_flag}, 32'h1);
		rd(OFS_CTRL, "go clear", 32'h1);
		rd(OFS_STATUS, "done", 32'h3);
		rd(OFS_RES_HI, "res hi", ex_hi);
		rd(OFS_RES_LO, "res lo", ex_lo);
	endtask : conv

	task print_verdict;
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (40000) @(posedge pclk);
		n_fail++;
		print_verdict;
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(OFS_CTRL, "ctrl rst", 32'h0);
		rd(OFS_STATUS, "stat rst", 32'h2);
		apb(0, 8'h1C, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1, OFS_AMASK, 32'h00FF);
		rd(OFS_PORT, "port", 32'hFF00);
		apb(1, OFS_RES_HI, 32'h5A);
		rd(OFS_RES_HI, "hi write", 32'h5A);
		// go in the same write as power-on must be dropped
		apb(1, OFS_CTRL, 32'h3);
		rd(OFS_CTRL, "go dropped", 32'h1);
		chk("no start", {31'h0, hold_connect}, 32'h1);
		for (int c = 0; c < 8; c++) begin
			conv(3'(c), 3'h0, c[0], 10'(37 * c + 300));
		end
		for (int a = 1; a < 8; a++) begin
			conv(3'h0, 3'(a), 1'b1, 10'(101 * a));
		end
		// abort a slow conversion part way through
		apb(1, OFS_TIMING, 32'h86);
		apb(1, OFS_STATUS, 32'h1);
		apb(1, OFS_CTRL, 32'h3);
		wait_hold(0);
		repeat (200) @(posedge pclk);
		apb(1, OFS_CTRL, 32'h1);
		wait_hold(1);
		rd(OFS_STATUS, "no done", 32'h2);
		rd(OFS_RES_LO, "lo kept", 32'hC3);
		apb(1, OFS_CTRL, 32'h3);
		repeat (100) @(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(OFS_CTRL, "ctrl rst2", 32'h0);
		print_verdict;
	end
endmodule : test_acs_top
